// ### dv/tb_timer_channel_capture_compare.sv
// Testbench for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_capture_compare;
	import tcc_pkg::*;
	localparam logic [11:0] S0 = 12'h094, H0 = 12'h098, L0 = 12'h09c, S1 = 12'h0a0;
	localparam logic [11:0] H1 = 12'h0a4, L1 = 12'h0a8;
	logic slv_err;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wrap;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] cnt;
	logic [1:0] pin_in, pin_out, oe_n, irq, lvl;
	tcc_mode_t [1:0] mode;
	logic [7:0] rdat, cfg;
	int err_count, compares, cyc, el;
	tcc_capture_compare i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.counter_value(cnt), .counter_wrap(wrap), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
		.channel_pin_oe_n(oe_n), .channel_irq(irq), .channel_mode(mode));
	tcc_pin_model i_pins (.pin_out(pin_out), .oe_n(oe_n), .ext_lvl(lvl), .pin_in(pin_in));
	// Free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic close_out;
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer, held until ready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata[7:0];
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat, e);
	endtask : rd
	// Counter sits on a value for one cycle, optionally with a wrap
	task automatic match(input logic [15:0] v, input logic w);
		cnt <= v;
		wrap <= w;
		@(posedge pclk);
		cnt <= v + 16'h1;
		wrap <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : match
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, wrap} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		cnt = 16'h0;
		lvl = 2'h0;
		cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(S0, 8'h00);
		rd(S1, 8'h00);
		apb(1'b0, 12'h004, 8'h00);
		chk({7'h0, slv_err}, 8'h01);
		// Every capture edge code, rise then fall
		for (el = 1; el < 4; el++) begin
			cfg = 8'h40 | 8'(el << 2);
			apb(1'b1, S0, cfg);
			apb(1'b0, S0, 8'h00);
			apb(1'b1, S0, cfg);
			cnt <= 16'h1230 + 16'(el);
			lvl <= 2'h1;
			repeat (4) @(posedge pclk);
			rd(S0, cfg | {el != 2, 7'h0});
			apb(1'b1, S0, cfg);
			rd(S0, cfg);
			lvl <= 2'h0;
			repeat (4) @(posedge pclk);
			rd(S0, cfg | {el != 1, 7'h0});
		end
		chk({7'h0, irq[0]}, 8'h01);
		rd(H0, 8'h12);
		cnt <= 16'h5678;
		lvl <= 2'h1;
		repeat (4) @(posedge pclk);
		rd(L0, 8'h33);
		apb(1'b1, S0, 8'h8c);
		repeat (3) @(posedge pclk);
		chk({7'h0, irq[0]}, 8'h00);
		rd(S0, 8'h8c);
		// Compare actions: set, clear, toggle; counter held still across mode changes
		apb(1'b1, H0, 8'h00);
		apb(1'b1, L0, 8'h40);
		for (el = 3; el > 0; el--) begin
			apb(1'b1, S0, 8'h10 | 8'(el << 2));
			match(16'h0040, 1'b0);
			chk({7'h0, pin_out[0]}, {7'h0, el != 2});
		end
		chk({6'h0, mode[0]}, {6'h0, TCC_MODE_COMPARE});
		chk({7'h0, oe_n[0]}, 8'h00);
		apb(1'b1, H0, 8'h00);
		match(16'h0040, 1'b0);
		chk({7'h0, pin_out[0]}, 8'h01);
		apb(1'b1, L0, 8'h40);
		match(16'h0040, 1'b0);
		chk({7'h0, pin_out[0]}, 8'h00);
		apb(1'b1, S0, 8'h16);
		match(16'h0100, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h01);
		apb(1'b1, S0, 8'h1e);
		match(16'h0040, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h00);
		// Full duty: takes hold after one wrap, releases after the next
		apb(1'b1, S0, 8'h1f);
		match(16'h0100, 1'b1);
		match(16'h0100, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h01);
		apb(1'b1, S0, 8'h1e);
		match(16'h0100, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h01);
		match(16'h0100, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h00);
		// No toggle on wrap: level only repeated
		apb(1'b1, S0, 8'h1c);
		match(16'h0040, 1'b0);
		match(16'h0100, 1'b1);
		chk({7'h0, pin_out[0]}, 8'h01);
		// Channel 1 preset low, pin left to the port
		apb(1'b1, H1, 8'h00);
		apb(1'b1, L1, 8'h50);
		apb(1'b1, S1, 8'h10);
		repeat (2) @(posedge pclk);
		chk({7'h0, pin_out[1]}, 8'h00);
		chk({7'h0, oe_n[1]}, 8'h01);
		chk({7'h0, irq[1]}, 8'h00);
		// Buffered pairing frees channel 1
		apb(1'b1, S0, 8'h3c);
		apb(1'b1, S1, 8'h5c);
		rd(S1, 8'h00);
		chk({6'h0, mode[0]}, {6'h0, TCC_MODE_BUFFERED});
		chk({7'h0, oe_n[1]}, 8'h01);
		// Buffered toggle: channel 1 value live only after a wrap
		apb(1'b1, S0, 8'h34);
		match(16'h0050, 1'b0);
		chk({7'h0, pin_out[0]}, 8'h01);
		match(16'h0100, 1'b1);
		match(16'h0050, 1'b0);
		chk({7'h0, pin_out[0]}, 8'h00);
		close_out();
	end
endmodule : tb_timer_channel_capture_compare
`default_nettype wire

// ### dv/tcc_assertions.sv
// Port checker for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tcc_chk import tcc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] channel_pin_oe_n,
	input wire logic [1:0] channel_irq,
	input wire tcc_mode_t [1:0] channel_mode
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed write, the only cause of a mode change
	wire wr = pready && pwrite;
	chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
	chk_irq_flag: assert property (pready && !pwrite && !pslverr && paddr == 12'h094 && prdata[7:6] == 2'h3
		|-> channel_irq[0]) else $error("irq missing");
	chk_irq_mask: assert property (wr && paddr == 12'h094 && !pwdata[6] |-> ##3 !channel_irq[0]) else $error("irq");
	// Two cycles of a mode; the pin enable changes on the same edge as the mode output
	chk_off_released: assert property ((channel_mode[0] == TCC_MODE_PRESET ||
		channel_mode[0] == TCC_MODE_CAPTURE) [*2] |-> channel_pin_oe_n[0]) else $error("pin driven");
	chk_cmp_drives: assert property ((channel_mode[0] == TCC_MODE_COMPARE) [*2] |-> !channel_pin_oe_n[0])
		else $error("pin not driven");
	chk_pair_frees: assert property ((channel_mode[0] == TCC_MODE_BUFFERED) [*2] |-> channel_pin_oe_n[1])
		else $error("pin 1 held");
	chk_mode_cause: assert property ($changed(channel_mode) |-> $past(wr) || $past(wr, 2)) else $error("mode");
	cover property (channel_irq[0]);
	cover property (channel_mode[0] == TCC_MODE_COMPARE);
	cover property (channel_mode[0] == TCC_MODE_BUFFERED);
endmodule : tcc_chk
bind tcc_capture_compare tcc_chk i_chk (.*);
`default_nettype wire

// ### dv/tcc_pin_model.sv
// Outside world seen by the two channel pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
	input wire logic [1:0] pin_out,
	input wire logic [1:0] oe_n,
	input wire logic [1:0] ext_lvl,
	output logic [1:0] pin_in
);
	// Device drive wins while enabled, else the outside level
	assign pin_in = (pin_out & ~oe_n) | (ext_lvl & oe_n);
endmodule : tcc_pin_model
`default_nettype wire

// ### rtl/tcc_capture_compare.sv
// Two-channel timer capture/compare logic with APB register access
// Structure
// The block holds two channels that share one counter.
// The counter, its prescaler and its modulo logic live outside.
// Counter value and wrap pulse arrive as plain inputs.
// Both inputs are taken as synchronous to the bus clock.
//
// Register access
// Every register is one byte in the low lane of an aligned word.
// The word index is the register's number; the byte address is four times it.
// Unmapped or misaligned addresses answer with an error and do nothing.
// Every transfer completes without wait states.
// Read data is latched in the setup cycle and shown with ready.
//
// Modes
// Preset: pin belongs to the port; low mode select gives its idle level.
// Capture: active edges copy the counter into the value register.
// Compare: a counter match drives the pin as the edge field asks.
// Buffered: channel 0 runs the pair, channel 1 goes back to the port.
// Buffer select wins over mode select and an off edge field of channel 0.
//
// Flag handling
// A flag is armed by a status read that sees it set.
// A later write of zero clears it only while it stays armed.
// A new event in the same cycle wins and disarms the flag.
// So a request can never be lost to a careless clear.
//
// Pulse width operation
// Toggle on wrap plus a compare action make the pulse.
// Full duty force is sampled only at the wrap pulse.
// Thus setting or clearing it takes effect one period later.
// The forced level is high for set-on-compare, low otherwise.
// Without toggle on wrap a set or clear match only repeats its level: no pulse.
//
// Byte pairing
// Reading the high value byte freezes capture until the low byte is read.
// Writing the high value byte freezes compare until the low byte is written.
// This keeps software from seeing or using a torn 16-bit value.
//
// Limitations
// Value registers have no reset; software must load them before use.
// Mode changes take effect at once; software should halt the counter first.
// The pin drive register sits one clock behind the decision logic.
// The interrupt output lags the flag by one clock.
//
// Implementation choice: the APB slave port.
`include "tcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] counter_value,
	input wire logic counter_wrap,
	input wire logic [1:0] channel_pin_in,
	output logic [1:0] channel_pin_out,
	output logic [1:0] channel_pin_oe_n,
	output logic [1:0] channel_irq,
	output var tcc_pkg::tcc_mode_t [1:0] channel_mode
);
	import tcc_pkg::*;

	// Bus decode
	wire logic setup = psel && !penable;
	wire logic access_wr = psel && penable && pwrite;
	wire logic access_rd = psel && penable && !pwrite;
	wire logic [9:0] idx = paddr[11:2];
	wire logic aligned = (paddr[1:0] == 2'h0);
	wire logic hit_sc0 = aligned && idx == {2'h0, `TCC_IDX_CH0_SC};
	wire logic hit_sc1 = aligned && idx == {2'h0, `TCC_IDX_CH1_SC};
	wire logic hit_h0 = aligned && idx == {2'h0, `TCC_IDX_CH0_HI};
	wire logic hit_l0 = aligned && idx == {2'h0, `TCC_IDX_CH0_LO};
	wire logic hit_h1 = aligned && idx == {2'h0, `TCC_IDX_CH1_HI};
	wire logic hit_l1 = aligned && idx == {2'h0, `TCC_IDX_CH1_LO};
	wire logic hit_any = hit_sc0 | hit_sc1 | hit_h0 | hit_l0 | hit_h1 | hit_l1;

	// Control registers per channel
	logic [1:0] flag_q;
	logic [1:0] ie_q;
	logic msb_q; // Only channel 0 owns buffer select
	logic [1:0] msa_q;
	logic [1:0] elb_q;
	logic [1:0] ela_q;
	logic [1:0] tov_q;
	logic [1:0] max_q;
	logic [1:0] armed_q; // Flag seen set by a status read
	logic [15:0] val_q [2];
	logic [1:0] cap_blk_q;
	logic [1:0] cmp_blk_q;
	logic [1:0] pin_prev_q;
	logic [1:0] pin_q;
	logic [1:0] oe_n_q;
	logic [1:0] max_act_q; // Full duty latched at cycle boundary
	logic sel1_q; // Buffered: which value register is live
	logic [1:0] irq_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	tcc_mode_t [1:0] mode_q;

	// Decoded per-channel modes; buffer select wins and blanks channel 1
	tcc_mode_t mode [2];
	logic [1:0] el [2];
	logic [1:0] event_hit;
	logic [1:0] match;
	logic [1:0] pin_next;
	logic [7:0] sc_rd [2];
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			el[c] = {elb_q[c], ela_q[c]};
			if (c == 1 && msb_q)
				mode[c] = TCC_MODE_PRESET;
			else if (el[c] == `TCC_EL_OFF && !(c == 0 && msb_q))
				mode[c] = TCC_MODE_PRESET;
			else if (c == 0 && msb_q)
				mode[c] = TCC_MODE_BUFFERED;
			else if (msa_q[c])
				mode[c] = TCC_MODE_COMPARE;
			else
				mode[c] = TCC_MODE_CAPTURE;
			sc_rd[c] = {flag_q[c], ie_q[c], (c == 0) ? msb_q : 1'b0, msa_q[c], elb_q[c], ela_q[c],
				tov_q[c], max_q[c]};
		end
		if (msb_q)
			sc_rd[1] = 8'h00; // Disabled register reads as zero
	end

	// Events: capture edges and compare matches
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic rise;
			logic fall;
			logic [15:0] cmpv;
			rise = channel_pin_in[c] && !pin_prev_q[c];
			fall = !channel_pin_in[c] && pin_prev_q[c];
			cmpv = (mode[c] == TCC_MODE_BUFFERED && sel1_q) ? val_q[1] : val_q[c];
			match[c] = (mode[c] == TCC_MODE_COMPARE || mode[c] == TCC_MODE_BUFFERED) && !cmp_blk_q[c]
				&& counter_value == cmpv;
			event_hit[c] = match[c];
			if (mode[c] == TCC_MODE_CAPTURE && !cap_blk_q[c])
				event_hit[c] = (el[c] == `TCC_EL_RISE && rise) || (el[c] == `TCC_EL_FALL && fall)
					|| (el[c] == `TCC_EL_ANY && (rise || fall));
		end
	end

	// Output pin next value
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pin_next[c] = pin_q[c];
			if (mode[c] == TCC_MODE_PRESET)
				pin_next[c] = !msa_q[c]; // one gives low
			else if (mode[c] == TCC_MODE_COMPARE || mode[c] == TCC_MODE_BUFFERED) begin
				if (tov_q[c] && max_act_q[c])
					pin_next[c] = (el[c] == `TCC_EL_SET) ? 1'b1 : 1'b0;
				else if (tov_q[c] && counter_wrap)
					pin_next[c] = !pin_q[c];
				else if (match[c]) begin
					case (el[c])
						`TCC_EL_TOG: pin_next[c] = !pin_q[c];
						`TCC_EL_CLR: pin_next[c] = 1'b0;
						`TCC_EL_SET: pin_next[c] = 1'b1;
						default: pin_next[c] = pin_q[c]; // software compare only
					endcase
				end
			end
		end
	end

	// Read data mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (hit_sc0)
			rd_mux = {24'h0, sc_rd[0]};
		else if (hit_sc1)
			rd_mux = {24'h0, sc_rd[1]};
		else if (hit_h0)
			rd_mux = {24'h0, val_q[0][15:8]};
		else if (hit_l0)
			rd_mux = {24'h0, val_q[0][7:0]};
		else if (hit_h1)
			rd_mux = {24'h0, val_q[1][15:8]};
		else if (hit_l1)
			rd_mux = {24'h0, val_q[1][7:0]};
	end

	// APB answer: no wait state, data valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready <= setup;
			prdata_q <= setup ? rd_mux : prdata_q;
			pslverr_q <= setup && !hit_any;
		end
	end
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	wire logic wr_done = access_wr && pready;
	wire logic rd_done = access_rd && pready;
	wire logic [7:0] wb = pwdata[7:0];
	// Status writes per channel; channel 1 is deaf while paired
	wire logic [1:0] wr_sc = {wr_done && hit_sc1 && !msb_q, wr_done && hit_sc0};
	// Note: byte lane above bit 7 is ignored on every write
	// Note: status reads never disturb the flag itself

	// Channel state, flags and control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 2'h0;
			ie_q <= 2'h0;
			msb_q <= 1'b0;
			msa_q <= 2'h0;
			elb_q <= 2'h0;
			ela_q <= 2'h0;
			tov_q <= 2'h0;
			max_q <= 2'h0;
			armed_q <= 2'h0;
			cap_blk_q <= 2'h0;
			cmp_blk_q <= 2'h0;
			pin_prev_q <= 2'h0;
			max_act_q <= 2'h0;
			sel1_q <= 1'b0;
		end else begin
			pin_prev_q <= channel_pin_in;
			if (counter_wrap) begin
				max_act_q <= max_q; // takes hold at cycle boundary
				sel1_q <= msb_q ? !sel1_q : 1'b0;
			end
			for (int c = 0; c < 2; c++) begin
				// Arm the clear when a read sees the flag set
				if (rd_done && ((c == 0) ? hit_sc0 : hit_sc1) && flag_q[c])
					armed_q[c] <= 1'b1;
				if (event_hit[c]) begin
					flag_q[c] <= 1'b1; // event wins
					armed_q[c] <= 1'b0;
				end else if (wr_sc[c] && !wb[`TCC_B_FLAG] && armed_q[c]) begin
					flag_q[c] <= 1'b0;
					armed_q[c] <= 1'b0;
				end
				// Control bits load on any accepted status write
				if (wr_sc[c]) begin
					ie_q[c] <= wb[`TCC_B_IE];
					msa_q[c] <= wb[`TCC_B_MSA];
					elb_q[c] <= wb[`TCC_B_ELSB];
					ela_q[c] <= wb[`TCC_B_ELSA];
					tov_q[c] <= wb[`TCC_B_TOV];
					max_q[c] <= wb[`TCC_B_MAX];
					if (c == 0)
						msb_q <= wb[`TCC_B_MSB];
				end
				// Byte-pair latching of value register
				if (rd_done && ((c == 0) ? hit_h0 : hit_h1) && mode[c] == TCC_MODE_CAPTURE)
					cap_blk_q[c] <= 1'b1;
				else if (rd_done && ((c == 0) ? hit_l0 : hit_l1))
					cap_blk_q[c] <= 1'b0;
				if (wr_done && ((c == 0) ? hit_h0 : hit_h1) && mode[c] != TCC_MODE_CAPTURE)
					cmp_blk_q[c] <= 1'b1;
				else if (wr_done && ((c == 0) ? hit_l0 : hit_l1))
					cmp_blk_q[c] <= 1'b0;
			end
		end
	end

	// Value registers have no reset
	// Capture wins over a bus write in the same cycle, so a fresh
	// capture is never overwritten by a stale software value.
	// Software should not write a value register in capture mode.
	always_ff @(posedge pclk) begin
		for (int c = 0; c < 2; c++) begin
			if (mode[c] == TCC_MODE_CAPTURE && event_hit[c])
				val_q[c] <= counter_value;
			else if (wr_done && ((c == 0) ? hit_h0 : hit_h1))
				val_q[c][15:8] <= wb;
			else if (wr_done && ((c == 0) ? hit_l0 : hit_l1))
				val_q[c][7:0] <= wb;
		end
	end

	// Pins, interrupt and mode outputs
	// All top outputs come from flops so the pins never glitch
	// while the decode logic settles after a register write.
	// Pin drive idles high so a port pull-up sees no dip.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 2'h3;
			oe_n_q <= 2'h3;
			irq_q <= 2'h0;
			// Both channels come up in preset mode
			mode_q[0] <= TCC_MODE_PRESET;
			mode_q[1] <= TCC_MODE_PRESET;
		end else begin
			pin_q <= pin_next;
			for (int c = 0; c < 2; c++) begin
				oe_n_q[c] <= !(mode[c] == TCC_MODE_COMPARE || mode[c] == TCC_MODE_BUFFERED);
				irq_q[c] <= ie_q[c] && flag_q[c];
				mode_q[c] <= mode[c];
			end
		end
	end
	// Buffered pair drives its output on the channel 0 pin
	assign channel_pin_out = pin_q;
	assign channel_pin_oe_n = oe_n_q;
	assign channel_irq = irq_q;
	assign channel_mode = mode_q;
endmodule : tcc_capture_compare
`default_nettype wire

// ### rtl/tcc_params.svh
// Constants for the two-channel timer capture/compare block
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
// Register indices (byte address is four times the index)
`define TCC_IDX_CH0_HI 8'h26
`define TCC_IDX_CH0_LO 8'h27
`define TCC_IDX_CH1_HI 8'h29
`define TCC_IDX_CH1_LO 8'h2a
`define TCC_IDX_CH0_SC 8'h25
`define TCC_IDX_CH1_SC 8'h28
// Status/control bit positions
`define TCC_B_FLAG 7
`define TCC_B_IE 6
`define TCC_B_MSB 5
`define TCC_B_MSA 4
`define TCC_B_ELSB 3
`define TCC_B_ELSA 2
`define TCC_B_TOV 1
`define TCC_B_MAX 0
// Edge/level codes
`define TCC_EL_OFF 2'h0
`define TCC_EL_TOG 2'h1
`define TCC_EL_CLR 2'h2
`define TCC_EL_SET 2'h3
`define TCC_EL_RISE 2'h1
`define TCC_EL_FALL 2'h2
`define TCC_EL_ANY 2'h3
`endif

// ### rtl/tcc_pkg.sv
// Types for the two-channel timer capture/compare block
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_MODE_PRESET = 2'b00,
		TCC_MODE_CAPTURE = 2'b01,
		TCC_MODE_COMPARE = 2'b10,
		TCC_MODE_BUFFERED = 2'b11
	} tcc_mode_t;
endpackage : tcc_pkg
